// >>> rtl/fpma_pkg.sv
package fpma_pkg;
  localparam int NUM_PORTS = 4;  // channel ports
  localparam int DATA_W    = 16; // central bus word
  localparam int MOD_W     = 3;  // bus module number width
  localparam int MEM_W     = 2;  // memory module number width
  localparam int NUM_MEM   = 4;  // memory modules with ready lines

  // memory operation codes on the central bus
  localparam logic [1:0] OP_NONE = 2'h0; // no_operation_code
  localparam logic [1:0] OP_CW   = 2'h1; // clear_write_op
  localparam logic [1:0] OP_RR   = 2'h2; // read_restore_op

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00; // port enables
  localparam logic [7:0] OFS_STATUS = 8'h04; // port flags, module number
  localparam logic [7:0] ADDR_MASK  = 8'hFC;

  // control fields and reset value
  localparam int          CTRL_EN_LSB = 0;
  localparam logic [3:0]  CTRL_RESET  = 4'hF;
  // status fields: four bits per port, module number above
  localparam int STAT_PORT_W  = 4;
  localparam int STAT_MOD_LSB = 16;

  // central bus word with its routing codes
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
    logic [MOD_W-1:0]  dest;
    logic [MOD_W-1:0]  src;
    logic [1:0]        op;
  } fpmaBus_s;

  // inputs that come from outside and are synchronised
  typedef struct packed {
    logic [NUM_PORTS-1:0]            writeReq;
    logic [NUM_PORTS-1:0]            readReq;
    logic [NUM_PORTS-1:0][MEM_W-1:0] dest;
    logic [DATA_W-1:0]               port_shared_data_lines;
    logic                            grant;
    logic [NUM_MEM-1:0]              ready;
    logic [MOD_W-1:0]                moduleId;
    logic                            inValid;
    logic [DATA_W-1:0]               inData;
    logic [MOD_W-1:0]                inDest;
    logic [MOD_W-1:0]                inSrc;
  } fpmaPins_s;

  // per-port request flags
  typedef struct packed {
    logic             address_phase_request;
    logic             mopWrite;
    logic [MEM_W-1:0] toA;
    logic [MEM_W-1:0] toB;
    logic             data_phase_request;
    logic             waitData;
  } fpmaPort_s;
endpackage

// >>> rtl/fpma_top.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module fpma_top (
  // clock and reset
  input  wire logic                                         core_clk,
  input  wire logic                                         rst,
  // ahb-lite slave
  input  wire logic                                         hsel,
  input  wire logic [31:0]                                  haddr,
  input  wire logic [1:0]                                   htrans,
  input  wire logic                                         hwrite,
  input  wire logic [2:0]                                   hsize,
  input  wire logic [31:0]                                  hwdata,
  input  wire logic                                         hready,
  output logic                                              hreadyout,
  output logic [31:0]                                       hrdata,
  output logic                                              hresp,
  // channel side, one set per port
  input  wire logic [fpma_pkg::NUM_PORTS-1:0]               writeTypeRequest,
  input  wire logic [fpma_pkg::NUM_PORTS-1:0]               readTypeRequest,
  input  wire logic [fpma_pkg::NUM_PORTS-1:0][fpma_pkg::MEM_W-1:0] destinationModuleField,
  output logic [fpma_pkg::NUM_PORTS-1:0]                    addressPhaseSelect,
  output logic [fpma_pkg::NUM_PORTS-1:0]                    dataPhaseSelect,
  output logic [fpma_pkg::NUM_PORTS-1:0]                    readReturnStrobe,
  // channel side, shared data lines
  input  wire logic [fpma_pkg::DATA_W-1:0]                  portSharedDataIn,
  output logic [fpma_pkg::DATA_W-1:0]                       portSharedDataOut,
  // wired module number
  input  wire logic [fpma_pkg::MOD_W-1:0]                   moduleNumber,
  // central bus, transmit side
  input  wire logic                                         busTransmitGrant,
  output fpma_pkg::fpmaBus_s                                busOut,
  // memory ready lines, open drain
  input  wire logic [fpma_pkg::NUM_MEM-1:0]                 moduleReadyIn,
  output logic [fpma_pkg::NUM_MEM-1:0]                      moduleReadyOut,
  output logic [fpma_pkg::NUM_MEM-1:0]                      moduleReadyOe,
  // central bus, receive side
  input  wire logic                                         busInValid,
  input  wire logic [fpma_pkg::DATA_W-1:0]                  busInData,
  input  wire logic [fpma_pkg::MOD_W-1:0]                   busInDest,
  input  wire logic [fpma_pkg::MOD_W-1:0]                   busInSrc
);
  import fpma_pkg::*;

  // overview of the block:
  //   outside inputs except clock, reset and the ahb pins
  //   pass two flip-flops, so the logic sees
  //   those pins two cycles late, grant and ready too
  //   one next-state process fills s_nxt,
  //   one clocked process registers it
  //   at most one word goes out per cycle:
  //   an owed data word first, else the
  //   best address word among the ports
  //   returned words are matched on their
  //   own, in parallel with transmission
  //   registers sit on a zero-wait slave
  //   with one cycle of write pipelining
  //   no interrupt logic lives here

  // whole module state, one packed struct
  //   selects, strobe, ready pull, bus op and
  //   bus valid are one-cycle pulses;
  //   everything else holds until changed
  //   the port flags carry a transfer from
  //   its request to its data word or strobe
  //   the returned word stays on the channel
  //   lines until the next return
  typedef struct packed {
    fpmaPins_s                     pinA;       // first sync stage
    fpmaPins_s                     pinB;       // second sync stage
    fpmaPort_s [NUM_PORTS-1:0]     port;       // per-port flags
    logic [NUM_PORTS-1:0]          addrSel;    // low select pulses
    logic [NUM_PORTS-1:0]          dataSel;    // high select pulses
    logic [NUM_PORTS-1:0]          strobe;     // read return pulses
    logic [DATA_W-1:0]             pcdOut;     // returned read word
    fpmaBus_s                      bus;        // transmitted word
    logic [NUM_MEM-1:0]            readyOe;    // ready pull-low
    logic [3:0]                    portEnable; // control register
    logic                          wrPend;     // ahb write data phase
    logic [7:0]                    wrAddr;     // ahb write offset
    logic [31:0]                   rdata;      // ahb read data
  } fpmaState_s;

  // s_nxt starts as a copy of s_r, so a
  // field not named below keeps its value
  fpmaState_s s_r;   // registered state
  fpmaState_s s_nxt; // next state

  // raw pins, before any flip-flop; only
  // the first synchroniser stage reads it
  fpmaPins_s pinsNow; // raw pin bundle

  // status word: per-port flags plus module number
  //   nibble i holds port i's low request,
  //   write flag, high request and wait flag
  //   the module number is shown as seen
  //   after its synchroniser
  function automatic logic [31:0] statusWord(input fpmaState_s st);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < NUM_PORTS; i++) begin
      w[i*STAT_PORT_W +: STAT_PORT_W] = {st.port[i].waitData, st.port[i].data_phase_request,
                                         st.port[i].mopWrite, st.port[i].address_phase_request};
    end
    w[STAT_MOD_LSB +: MOD_W] = st.pinB.moduleId;
    return w;
  endfunction

  // word offset of a byte address: low
  // bits are dropped, only aligned words
  function automatic logic [7:0] regOfs(input logic [7:0] a);
    return a & ADDR_MASK;
  endfunction

  // register read decode
  //   unmapped offsets read as zero
  function automatic logic [31:0] readMux(input fpmaState_s st, input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (regOfs(ofs))
      OFS_CTRL:   w[CTRL_EN_LSB +: 4] = st.portEnable;
      OFS_STATUS: w = statusWord(st);
      default:    w = 32'h0000_0000; // unmapped reads zero
    endcase
    return w;
  endfunction

  // widen a memory number to a bus module number
  //   memories answer on the bus with their
  //   own number, zero-extended here
  function automatic logic [MOD_W-1:0] memToMod(input logic [MEM_W-1:0] m);
    return {{(MOD_W-MEM_W){1'b0}}, m};
  endfunction

  // bundle the outside inputs for synchronising
  //   data lines and the returned word are
  //   delayed with their qualifiers, so a
  //   request and its destination, or a
  //   valid and its word, stay together
  //   hazard: a level shorter than a cycle
  //   may be missed; channels hold a cycle
  always_comb begin
    pinsNow.writeReq = writeTypeRequest;
    pinsNow.readReq  = readTypeRequest;
    pinsNow.dest     = destinationModuleField;
    pinsNow.port_shared_data_lines      = portSharedDataIn;
    pinsNow.grant    = busTransmitGrant;
    pinsNow.ready    = moduleReadyIn;
    pinsNow.moduleId = moduleNumber;
    pinsNow.inValid  = busInValid;
    pinsNow.inData   = busInData;
    pinsNow.inDest   = busInDest;
    pinsNow.inSrc    = busInSrc;
  end

  // next-state logic
  //   order of work within one cycle:
  //   1. shift the synchronisers
  //   2. clear last cycle's pulses
  //   3. pick an owed data word, if any
  //   4. else pick the best address word
  //   5. match a returned word to a port
  //   6. take new channel requests
  //   7. run the register slave
  //   steps 5 to 7 read s_r and ahb pins, so
  //   their order does not change the
  //   result; the flags they touch differ
  always_comb begin
    fpmaPins_s p;
    logic      hiFound;
    int        hiIdx;
    logic      loFound;
    int        loIdx;
    logic      retFound;
    logic      eligible;
    p        = s_r.pinB;
    hiFound  = 1'b0;
    hiIdx    = 0;
    loFound  = 1'b0;
    loIdx    = 0;
    retFound = 1'b0;
    eligible = 1'b0;
    s_nxt    = s_r;

    // two-stage synchroniser
    //   only the second stage feeds logic,
    //   the first may still be settling
    s_nxt.pinA = pinsNow;
    s_nxt.pinB = s_r.pinA;

    // pulses last one cycle
    //   bus data, dest and src keep their
    //   last value; only valid marks a word
    s_nxt.addrSel   = '0;
    s_nxt.dataSel   = '0;
    s_nxt.strobe    = '0;
    s_nxt.readyOe   = '0;
    s_nxt.bus.valid = 1'b0;
    s_nxt.bus.op    = OP_NONE;

    // find a pending high request
    //   at most one can be owed at a time,
    //   the lowest index is taken anyway
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (s_r.port[i].data_phase_request && !hiFound) begin
        hiFound = 1'b1;
        hiIdx   = i;
      end
    end

    // lowest ready low request wins
    //   a port still owing a data word or
    //   awaiting a returned word is held
    //   back, so its queued request waits
    //   ready is the synchronised line and
    //   lags two cycles; the owed data word
    //   always goes first, so a memory just
    //   pulled low is never picked stale
    for (int i = 0; i < NUM_PORTS; i++) begin
      eligible = s_r.port[i].address_phase_request && !s_r.port[i].data_phase_request && !s_r.port[i].waitData
                 && p.ready[s_r.port[i].toA];
      if (eligible && !loFound) begin
        loFound = 1'b1;
        loIdx   = i;
      end
    end

    // one transmission per granted cycle
    //   grant is sampled through the
    //   synchroniser like every non-ahb input but clock and reset; without
    //   it nothing is sent and flags stay
    //   a data word always beats an address
    //   word, whatever port asks for it, so
    //   a write is never split by another
    if (p.grant && hiFound) begin
      // data word of a write, ahead of any low request
      //   channel data lines carry the word;
      //   dest comes from the copied register
      s_nxt.port[hiIdx].data_phase_request = 1'b0;
      s_nxt.dataSel[hiIdx]   = 1'b1;
      s_nxt.bus.valid        = 1'b1;
      s_nxt.bus.data         = p.port_shared_data_lines;
      s_nxt.bus.dest         = memToMod(s_r.port[hiIdx].toB);
      s_nxt.bus.src          = p.moduleId;
      s_nxt.bus.op           = OP_NONE;
    end else if (p.grant && loFound) begin
      // address word
      //   the destination register is copied
      //   so a new request may reload it
      s_nxt.port[loIdx].address_phase_request = 1'b0;
      s_nxt.port[loIdx].toB  = s_r.port[loIdx].toA;
      s_nxt.addrSel[loIdx]   = 1'b1;
      s_nxt.bus.valid        = 1'b1;
      s_nxt.bus.data         = p.port_shared_data_lines;
      s_nxt.bus.dest         = memToMod(s_r.port[loIdx].toA);
      s_nxt.bus.src          = p.moduleId;
      if (s_r.port[loIdx].mopWrite) begin
        s_nxt.bus.op                     = OP_CW;
        s_nxt.port[loIdx].data_phase_request           = 1'b1;
        s_nxt.readyOe[s_r.port[loIdx].toA] = 1'b1;
      end else begin
        // read: no data word owed, wait for
        // the memory to send the word back
        s_nxt.bus.op                 = OP_RR;
        s_nxt.port[loIdx].waitData   = 1'b1;
      end
    end

    // returned read data addressed to us
    //   dest must be our own number and src
    //   the memory this port addressed
    //   one word per cycle comes back, so at
    //   most one strobe; with two ports
    //   waiting on one memory the lower
    //   index takes the word
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (s_r.port[i].waitData && !retFound && p.inValid
          && p.inDest == p.moduleId
          && p.inSrc == memToMod(s_r.port[i].toB)) begin
        retFound               = 1'b1;
        s_nxt.strobe[i]        = 1'b1;
        s_nxt.pcdOut           = p.inData;
        s_nxt.port[i].waitData = 1'b0;
      end
    end

    // accept channel requests into idle low flags
    //   a busy flag ignores the request
    //   without sign; a held level asks
    //   again after each address select
    //   write wins when both lines are up
    //   a disabled port takes nothing
    //   the flag frees at the address select,
    //   before the earlier transfer is done
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!s_r.port[i].address_phase_request && s_r.portEnable[i]
          && (p.writeReq[i] || p.readReq[i])) begin
        s_nxt.port[i].address_phase_request     = 1'b1;
        s_nxt.port[i].mopWrite = p.writeReq[i];
        s_nxt.port[i].toA      = p.dest[i];
      end
    end

    // ahb write data phase
    //   hwdata stands one cycle after the
    //   address; only the control register
    //   is writable, other offsets drop it
    if (s_r.wrPend) begin
      s_nxt.wrPend = 1'b0;
      if (regOfs(s_r.wrAddr) == OFS_CTRL) begin
        s_nxt.portEnable = hwdata[CTRL_EN_LSB +: 4];
      end
    end

    // ahb address phase
    //   zero-wait: the read word is ready
    //   at the end of the address phase
    //   hazard: a read right behind a write
    //   to control would see the old value,
    //   so the data in flight is forwarded
    //   hsize is not decoded, whole words
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        s_nxt.wrPend = 1'b1;
        s_nxt.wrAddr = haddr[7:0];
      end else if (s_r.wrPend && (regOfs(s_r.wrAddr) == regOfs(haddr[7:0]))
                   && (regOfs(haddr[7:0]) == OFS_CTRL)) begin
        // forward a write still in its data phase
        s_nxt.rdata = {28'h000_0000, hwdata[CTRL_EN_LSB +: 4]};
      end else begin
        s_nxt.rdata = readMux(s_r, haddr[7:0]);
      end
    end
  end

  // state register with synchronous reset
  //   reset clears every flag, pulse and
  //   both synchroniser stages, and turns
  //   all four ports on; a transfer cut
  //   by reset is lost, the channel must
  //   ask again
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r            <= '0;
      s_r.portEnable <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // limitations a user must know:
  //   requests, grant and ready are seen
  //   two cycles late, so a transfer takes
  //   at least four cycles from the pin
  //   a port asks again only after its
  //   address select; a second request
  //   waits until the first has finished
  //   returns are matched by number only

  // outputs straight from state
  //   every output is a state field or a
  //   constant; the ready line is only
  //   ever pulled low, never driven high
  always_comb begin
    hreadyout          = 1'b1; // never waits
    hresp              = 1'b0; // always okay
    hrdata             = s_r.rdata;
    addressPhaseSelect = s_r.addrSel;
    dataPhaseSelect    = s_r.dataSel;
    readReturnStrobe   = s_r.strobe;
    portSharedDataOut  = s_r.pcdOut;
    busOut             = s_r.bus;
    moduleReadyOut     = '0;
    moduleReadyOe      = s_r.readyOe;
  end
endmodule
`default_nettype wire

// >>> verification/fpma_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fpma_top_properties (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst,
  // port selects and strobe
  input wire logic [3:0]          addressPhaseSelect,
  input wire logic [3:0]          dataPhaseSelect,
  input wire logic [3:0]          readReturnStrobe,
  // central bus and ready lines
  input wire fpma_pkg::fpmaBus_s  busOut,
  input wire logic [3:0]          moduleReadyOe,
  input wire logic [2:0]          moduleNumber,
  input wire logic                busInValid,
  input wire logic [2:0]          busInDest
);
  import fpma_pkg::*;
  logic [3:0] a;          // address selects
  logic [3:0] d;          // data selects
  logic       cw;         // write address word now
  logic [3:0] rdPend_r;   // ports awaiting a returned word
  logic [2:0] lastDest_r; // destination of last write address
  logic       hiPend_r;   // write data word still owed
  assign a = addressPhaseSelect;
  assign d = dataPhaseSelect;
  assign cw = |a && busOut.op == OP_CW;
  // track waiting reads and the write destination
  always_ff @(posedge core_clk) begin
    rdPend_r <= rst ? 4'h0 : (rdPend_r | (busOut.op == OP_RR ? a : 4'h0)) & ~readReturnStrobe;
    hiPend_r <= rst ? 1'b0 : (hiPend_r || cw) && !(|d);
    if (cw) begin
      lastDest_r <= busOut.dest;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_one_sender: assert property ($onehot0({a, d}) && busOut.valid == |{a, d})
    else $error("two ports transmit at once");
  a_addr_word: assert property (|a |-> busOut.op != OP_NONE && busOut.src == moduleNumber)
    else $error("address word codes wrong");
  a_data_word: assert property (|d |-> busOut.op == OP_NONE && busOut.dest == lastDest_r)
    else $error("data word codes wrong");
  a_write_pair: assert property (cw |=> ##[0:40] |d)
    else $error("write address without data word");
  a_high_first: assert property (hiPend_r |-> !(|a))
    else $error("address sent while data word pending");
  a_ready_pull: assert property (moduleReadyOe == (cw ? 4'h1 << busOut.dest[1:0] : 4'h0))
    else $error("ready pull wrong");
  a_queue_hold: assert property ((a & rdPend_r) == 4'h0)
    else $error("queued request granted too early");
  a_strobe_src: assert property (|readReturnStrobe |-> $past(busInValid, 3)
    && $past(busInDest, 3) == moduleNumber && $onehot(readReturnStrobe) && (readReturnStrobe & ~rdPend_r) == 4'h0)
    else $error("strobe without matching return");
  c_write: cover property (cw ##1 |d);
  c_strobe: cover property (|readReturnStrobe);
  c_queued: cover property (|a && |rdPend_r);
endmodule
`default_nettype wire

// >>> verification/fpma_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpma_mem_model (
  // clock and watched bus
  input wire logic               core_clk,
  input wire fpma_pkg::fpmaBus_s busOut,
  input wire logic [3:0]         moduleReadyOe,
  // held-off memories, read latency
  input wire logic [3:0]         holdOff,
  input wire logic [3:0]         lat,
  // memory side
  output logic [3:0]             moduleReadyIn,
  output logic                   busInValid,
  output logic [15:0]            busInData,
  output logic [2:0]             busInDest,
  output logic [2:0]             busInSrc
);
  import fpma_pkg::*;
  logic [3:0]  busy_r;   // memories awaiting write data
  logic [53:0] retQ[$];  // due cycle, dest, src, word
  int          cyc;      // cycle count
  initial begin
    busy_r = 4'h0;
    busInValid = 1'b0;
    busInData = 16'h0;
    busInDest = 3'h0;
    busInSrc = 3'h0;
    cyc = 0;
  end
  // wired ready: memory free and nobody pulling low
  assign moduleReadyIn = ~(busy_r | holdOff | moduleReadyOe);
  // accept words, return read data after the latency
  always @(posedge core_clk) begin
    cyc++;
    if (busOut.valid === 1'b1 && busOut.op == OP_CW) begin
      busy_r[busOut.dest[1:0]] <= 1'b1;
    end
    if (busOut.valid === 1'b1 && busOut.op == OP_NONE) begin
      busy_r[busOut.dest[1:0]] <= 1'b0;
    end
    if (busOut.valid === 1'b1 && busOut.op == OP_RR) begin
      retQ.push_back({32'(cyc + lat), busOut.src, busOut.dest, busOut.data ^ 16'h5A5A});
    end
    if (retQ.size() > 0 && retQ[0][53:22] <= cyc) begin
      busInValid <= 1'b1;
      {busInDest, busInSrc, busInData} <= retQ[0][21:0];
      void'(retQ.pop_front());
    end else begin
      // released bus shows the inverse word
      busInValid <= 1'b0;
      busInData <= ~busInData;
    end
  end
endmodule
`default_nettype wire

// >>> verification/fpma_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fpma_top_bench;
  import fpma_pkg::*;
  localparam logic [2:0] MODNUM = 3'h5;
  logic core_clk, rst, hsel, hwrite, hrdy, hresp, grant, inValid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [3:0] wr, rd, aSel, dSel, read_return_strobe, rdyIn, rdyOe, holdOff, lat, m;
  logic [7:0] dst;
  logic [15:0] port_shared_data_lines, pOut, inData;
  logic [2:0] inDest, inSrc;
  logic [25:0] gb, busQ[$];
  logic [17:0] gs, strbQ[$];
  fpmaBus_s busOut;
  int n_errors, checked, seed;
  fpma_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp),
    .writeTypeRequest(wr), .readTypeRequest(rd), .destinationModuleField(dst), .addressPhaseSelect(aSel),
    .dataPhaseSelect(dSel), .readReturnStrobe(read_return_strobe), .portSharedDataIn(port_shared_data_lines), .portSharedDataOut(pOut),
    .moduleNumber(MODNUM), .busTransmitGrant(grant), .busOut(busOut), .moduleReadyIn(rdyIn),
    .moduleReadyOut(), .moduleReadyOe(rdyOe), .busInValid(inValid), .busInData(inData), .busInDest(inDest),
    .busInSrc(inSrc));
  fpma_mem_model mem (.core_clk(core_clk), .busOut(busOut), .moduleReadyOe(rdyOe), .holdOff(holdOff),
    .lat(lat), .moduleReadyIn(rdyIn), .busInValid(inValid), .busInData(inData), .busInDest(inDest),
    .busInSrc(inSrc));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic [1:0] idx(input logic [3:0] s);
    return s[3] ? 2'h3 : s[2] ? 2'h2 : s[1] ? 2'h1 : 2'h0;
  endfunction
  // wait for hready, bounded
  task automatic hw();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask
  // one ahb-lite single word transfer
  task automatic ahb(input logic w, input logic [31:0] a, dat, e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hw();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    hw();
    cmp(0, hresp);
    if (!w) cmp(e, hrdata);
  endtask
  task automatic pulse(input logic [3:0] w, r);
    wr <= w;
    rd <= r;
    @(posedge core_clk);
    wr <= 4'h0;
    rd <= 4'h0;
  endtask
  // wait until all notes met, then new data and latency
  task automatic drain();
    int i;
    for (i = 0; i < 300 && busQ.size() + strbQ.size() > 0; i++) @(posedge core_clk);
    if (i == 300) begin
      n_errors++;
      conclude();
    end
    port_shared_data_lines <= 16'($random(seed));
    lat <= 4'($random(seed)) | 4'h1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic expect1(input int p, input logic w, input logic [1:0] ds);
    busQ.push_back({p[1:0], w ? OP_CW : OP_RR, 1'b0, ds, MODNUM, port_shared_data_lines});
    if (w) busQ.push_back({p[1:0], OP_NONE, 1'b0, ds, MODNUM, port_shared_data_lines});
    else strbQ.push_back({p[1:0], port_shared_data_lines ^ 16'h5A5A});
  endtask
  // requests on several ports, distinct destinations
  task automatic batch(input logic [3:0] w, r, input logic [1:0] x);
    int p;
    for (p = 0; p < 4; p++) begin
      dst[2*p+:2] <= p[1:0] ^ x;
      if (w[p] | r[p]) expect1(p, w[p], p[1:0] ^ x);
    end
    pulse(w, r);
  endtask
  // compare each word and strobe with the oldest note
  always @(posedge core_clk) begin
    if (!rst && busOut.valid === 1'b1) begin
      gb = {idx(aSel | dSel), busOut.op, busOut.dest, busOut.src, busOut.data};
      cmp(busQ.size() ? busQ.pop_front() : ~gb, gb);
    end
    if (!rst && |read_return_strobe === 1'b1) begin
      gs = {idx(read_return_strobe), pOut};
      cmp(strbQ.size() ? strbQ.pop_front() : ~gs, gs);
    end
  end
  initial begin
    seed = 32'hB2E1;
    n_errors = 0;
    checked = 0;
    {rst, grant} = 2'h3;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {wr, rd, dst, holdOff} = '0;
    port_shared_data_lines = 16'h1234;
    lat = 4'h2;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    ahb(0, 32'h0, 0, 32'hF);
    ahb(0, 32'h4, 0, {13'h0, MODNUM, 16'h0});
    ahb(0, 32'h8, 0, 0);
    ahb(1, 32'h0, 32'hE, 0);
    ahb(0, 32'h0, 0, 32'hE);
    pulse(4'h0, 4'h1);
    drain();
    ahb(1, 32'h0, 32'hF, 0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      batch(i[0] ? 4'h1 << i[2:1] : 4'h0, i[0] ? 4'h0 : 4'h1 << i[2:1], 2'($random(seed)));
      drain();
    end
    $display("test single done");
    for (int i = 0; i < 5; i++) begin
      m = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'($random(seed));
      batch(m, ~m, 2'($random(seed)));
      drain();
    end
    $display("test priority done");
    holdOff <= 4'h4;
    grant <= 1'b0;
    dst <= 8'h06;
    expect1(1, 0, 2'h1);
    expect1(0, 0, 2'h2);
    pulse(4'h0, 4'h3);
    repeat (10) @(posedge core_clk);
    cmp(2, busQ.size());
    grant <= 1'b1;
    repeat (10) @(posedge core_clk);
    cmp(1, busQ.size());
    holdOff <= 4'h0;
    drain();
    $display("test ready done");
    lat <= 4'hF;
    dst <= 8'h00;
    expect1(0, 0, 2'h0);
    expect1(0, 0, 2'h0);
    pulse(4'h0, 4'h1);
    for (int i = 0; i < 20 && aSel[0] !== 1'b1; i++) @(posedge core_clk);
    if (aSel[0] !== 1'b1) begin
      n_errors++;
      conclude();
    end
    pulse(4'h0, 4'h1);
    drain();
    $display("test queued done");
    conclude();
  end
endmodule
bind fpma_top fpma_top_properties props (.core_clk(core_clk), .rst(rst), .addressPhaseSelect(addressPhaseSelect),
  .dataPhaseSelect(dataPhaseSelect), .readReturnStrobe(readReturnStrobe), .busOut(busOut),
  .moduleReadyOe(moduleReadyOe), .moduleNumber(moduleNumber), .busInValid(busInValid), .busInDest(busInDest));
`default_nettype wire
